// *** logic/pmt_pkg.sv ***
// Constants, carrier types and the 4B/5B table for the transmit port.
// Assumes the transmit reference clock is sampled by a faster system clock.
package pmt_pkg;
   localparam int PMT_REF_HZ = 25_000_000;
   localparam int PMT_TX_CLK_FAST_HZ = 25_000_000;
   localparam int PMT_TX_CLK_SLOW_HZ = 2_500_000;
   // Reference rising edges per half period of the slow transmit clock
   localparam int PMT_DIV_HALF = PMT_REF_HZ / (2 * PMT_TX_CLK_SLOW_HZ);
   localparam logic [4:0] PMT_CODE_H = 5'h04;
   localparam logic [4:0] PMT_CODE_IDLE = 5'h1F;
   localparam logic [4:0] PMT_SYM_RESET = 5'h1F;
   localparam logic [3:0] PMT_RXD_RESET = 4'h0;
   localparam logic PMT_STRAP_IRQ_RESET = 1'b1;
   localparam logic PMT_STRAP_OP_MODE_STRAP_BIT0_RESET = 1'b0;

   typedef struct packed {
      logic en;
      logic er;
      logic [3:0] data;
   } pmt_tx_in_t;

   typedef struct packed {
      logic valid;
      logic [4:0] code;
   } pmt_sym_t;

   typedef struct packed {
      logic dv;
      logic er;
      logic [3:0] data;
   } pmt_rx_t;

   function automatic logic [4:0] pmt_enc(input logic [3:0] n);
      logic [4:0] c;
      c = 5'h1E;
      case (n)
         4'h0: c = 5'h1E;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0A;
         4'h5: c = 5'h0B;
         4'h6: c = 5'h0E;
         4'h7: c = 5'h0F;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'hA: c = 5'h16;
         4'hB: c = 5'h17;
         4'hC: c = 5'h1A;
         4'hD: c = 5'h1B;
         4'hE: c = 5'h1C;
         default: c = 5'h1D;
      endcase
      return c;
   endfunction
endpackage

// *** logic/pmt_tx_port.sv ***
// Transmit side of the media independent interface, with receive pin output and straps.
// Assumes clk is much faster than the reference clock; mode inputs share clk's domain.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE_01] A transmit nibble arrives on four data lines, line zero least significant.
// [RULE_02] At 100 Mb/s a high transmit error replaces the coded word with the /H/ code.
// [RULE_03] At 10 Mb/s the transmit error input has no effect at all.
// [RULE_04] In symbol mode coding is bypassed and the error pin is the fifth, top data bit.
// [RULE_05] The error pin is shared with the active-low interrupt and is unused in reduced-pin mode.
// [RULE_06] The MAC raises enable only over valid nibbles; only enabled data is sent.
// [RULE_07] In reduced-pin mode only the two low data lines are used.
// [RULE_08] The transmit clock runs at 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s.
// [RULE_09] In reduced-pin mode the transmit clock output is unused; the reference times it.
// [RULE_10] In reduced-pin mode the board should ground the two upper data lines.
// [RULE_11] Bit 0 of each receive nibble goes out on the first receive data line.
// [RULE_12] The first receive data pin is a strap giving bit 0 of the default mode.
// [RULE_13] Names starting with n are active low; reset holds the device while low.
// [RULE_14] The fourth receive data pin is strapped at reset: high picks interrupt, low error.
// [RULE_15] Receive valid is high while decoded nibbles are on the receive data lines.
// [RULE_16] Receive error is high when an error is found in the frame being passed on.
// [RULE_17] In the interface mode the inputs are taken on the rising transmit clock edge.
module pmt_tx_port (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ref_clk_in,
   input wire logic speed_100,
   input wire logic rmii_mode,
   input wire logic symbol_mode,
   input wire logic tx_en_in,
   input wire logic [3:0] txd_in,
   input wire logic shared_pin_in,
   output logic interrupt_out_low,
   output logic shared_pin_oe,
   input wire logic irq_req,
   output logic tx_clk_out,
   output pmt_pkg::pmt_sym_t sym_out,
   input wire pmt_pkg::pmt_rx_t rx_in,
   input wire logic [3:0] rxd_pin_in,
   output logic [3:0] rxd_out,
   output logic rxd_oe,
   output logic rx_dv_out,
   output logic rx_er_out,
   output logic op_mode_strap_bit0,
   output logic irq_pin_select_strap
);

   localparam int DIV_LAST = pmt_pkg::PMT_DIV_HALF - 1;

   if (pmt_pkg::PMT_DIV_HALF < 1 || pmt_pkg::PMT_DIV_HALF > 15) begin : g_div_check
      $error("Divider out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for pins
   pmt_pkg::pmt_tx_in_t tx_s1;
   pmt_pkg::pmt_tx_in_t tx_s2;
   logic ref_s1;
   logic ref_s2;
   logic ref_prev;
   logic [1:0] strap_s1;
   logic [1:0] strap_s2;

   always_ff @(posedge clk) begin
      tx_s1 <= '{en: tx_en_in, er: shared_pin_in, data: txd_in};
      tx_s2 <= tx_s1;
      ref_s1 <= ref_clk_in;
      ref_s2 <= ref_s1;
      ref_prev <= ref_s2;
      strap_s1 <= {rxd_pin_in[3], rxd_pin_in[0]};
      strap_s2 <= strap_s1;
   end

   logic ref_rise;
   assign ref_rise = ref_s2 & ~ref_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Straps caught while reset is held
   always_ff @(posedge clk) begin
      if (!rst_n) begin // RULE_13
         irq_pin_select_strap <= strap_s2[1]; // RULE_14
         op_mode_strap_bit0 <= strap_s2[0]; // RULE_12
      end
   end

   logic irq_mode;
   assign irq_mode = irq_pin_select_strap;

   // Open drain: pull low only while interrupt function is selected
   assign interrupt_out_low = 1'b0;
   assign shared_pin_oe = irq_mode & irq_req; // RULE_05

   ////////////////////////////////////////////////////////////////////////////
   // Transmit clock and sample tick
   logic [3:0] div_cnt;
   logic tx_clk_q;
   logic tick;
   logic next_tx_clk;

   always_comb begin
      next_tx_clk = tx_clk_q;
      if (speed_100) begin
         next_tx_clk = ref_s2;
      end else if (ref_rise && div_cnt == 4'(DIV_LAST)) begin
         next_tx_clk = ~tx_clk_q;
      end
   end
   assign tick = next_tx_clk & ~tx_clk_q; // RULE_17

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt <= 4'h0;
         tx_clk_q <= 1'b0;
      end else begin
         tx_clk_q <= next_tx_clk; // RULE_08
         if (speed_100) begin
            div_cnt <= 4'h0;
         end else if (ref_rise) begin
            div_cnt <= (div_cnt == 4'(DIV_LAST)) ? 4'h0 : div_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_clk_out <= 1'b0;
      end else begin
         tx_clk_out <= next_tx_clk & ~rmii_mode; // RULE_09
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Encoder
   logic dibit_phase;
   logic [1:0] dibit_low;
   logic er_used;
   assign er_used = tx_s2.er & ~irq_mode & ~rmii_mode; // RULE_05

   function automatic logic [4:0] code_of(input logic [3:0] n, input logic er,
                                          input logic fast, input logic sym);
      logic [4:0] c;
      c = {1'b0, n};
      if (fast && sym) begin
         c = {er, n}; // RULE_04
      end else if (fast && er) begin
         c = pmt_pkg::PMT_CODE_H; // RULE_02
      end else if (fast) begin
         c = pmt_pkg::pmt_enc(n);
      end
      return c; // RULE_03
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sym_out <= '{valid: 1'b0, code: pmt_pkg::PMT_SYM_RESET};
         dibit_phase <= 1'b0;
         dibit_low <= 2'h0;
      end else if (tick) begin
         if (!tx_s2.en) begin // RULE_06
            sym_out <= '{valid: 1'b0, code: pmt_pkg::PMT_CODE_IDLE};
            dibit_phase <= 1'b0;
         end else if (rmii_mode) begin
            if (!dibit_phase) begin
               dibit_low <= tx_s2.data[1:0]; // RULE_07
               dibit_phase <= 1'b1;
               sym_out.valid <= 1'b0;
            end else begin
               sym_out <= '{valid: 1'b1,
                  code: code_of({tx_s2.data[1:0], dibit_low}, 1'b0, speed_100, symbol_mode)};
               dibit_phase <= 1'b0;
            end
         end else begin
            sym_out <= '{valid: 1'b1,
               code: code_of(tx_s2.data, er_used, speed_100, symbol_mode)}; // RULE_01
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive pins; drive drops at once in reset so the strap pins show their pulls
   logic rx_drive;
   assign rxd_oe = rx_drive & rst_n; // RULE_14

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxd_out <= pmt_pkg::PMT_RXD_RESET;
         rx_drive <= 1'b0;
         rx_dv_out <= 1'b0;
         rx_er_out <= 1'b0;
      end else begin
         rxd_out <= rx_in.data; // RULE_11
         rx_drive <= 1'b1;
         rx_dv_out <= rx_in.dv; // RULE_15
         rx_er_out <= rx_in.er; // RULE_16
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_TXER_H: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
      tick && tx_s2.en && !rmii_mode && speed_100 && !symbol_mode && er_used
      |=> sym_out.valid && sym_out.code == pmt_pkg::PMT_CODE_H)
      else $error("Transmit error did not give the H code");

   AST_TEN_IGNORE_ER: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
      tick && tx_s2.en && !rmii_mode && !speed_100
      |=> sym_out.code == {1'b0, $past(tx_s2.data)})
      else $error("Slow mode output depends on transmit error");

   AST_SYMBOL: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
      tick && tx_s2.en && !rmii_mode && speed_100 && symbol_mode
      |=> sym_out.code == {$past(er_used), $past(tx_s2.data)})
      else $error("Symbol mode word wrong");

   AST_PIN_SHARE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
      (shared_pin_oe |-> irq_mode) and
      (tick && tx_s2.en && !rmii_mode && speed_100 && !symbol_mode && irq_mode
      |=> sym_out.code == pmt_pkg::pmt_enc($past(tx_s2.data))))
      else $error("Shared pin driven outside interrupt function");

   AST_ONLY_ENABLED: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
      tick && !tx_s2.en |=> !sym_out.valid ##1 ($stable(sym_out) || $past(tick)))
      else $error("Unqualified data sent");

   AST_RMII_PAIR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
      tick && rmii_mode && tx_s2.en && dibit_phase && speed_100 && !symbol_mode
      |=> sym_out.code == pmt_pkg::pmt_enc({$past(tx_s2.data[1:0]), $past(dibit_low)}))
      else $error("Reduced-pin nibble not paired from low dibits");

   AST_SLOW_CLK: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
      !speed_100 && $past(!speed_100) && $changed(tx_clk_q)
      |-> $past(ref_rise) && $past(div_cnt) == 4'(DIV_LAST))
      else $error("Slow transmit clock edge off the divider");

   AST_RMII_NO_TXCLK: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      rmii_mode |=> !tx_clk_out)
      else $error("Transmit clock driven in reduced-pin mode");

   AST_RXD0: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
      rst_n |=> rxd_out[0] == $past(rx_in.data[0]) && rx_dv_out == $past(rx_in.dv))
      else $error("Receive line zero or valid wrong");

   AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
      $past(rst_n) |-> $stable(op_mode_strap_bit0) && $stable(irq_pin_select_strap))
      else $error("Strap changed outside reset");

   AST_RESET_QUIET: assert property (@(posedge clk) // RULE_13
      !rst_n |=> !rx_dv_out && !rxd_oe && !sym_out.valid && !tx_clk_out)
      else $error("Outputs active during reset");

endmodule

// *** verif/pmt_mac_model.sv ***
// MAC model driving the transmit pins of the port.
// Assumes bench commands change on the falling clock edge.
`timescale 1ns/1ps
module pmt_mac_model (
   input wire logic clk,
   input wire logic rmii,
   input wire logic float_hi,
   input wire pmt_pkg::pmt_tx_in_t cmd,
   output logic tx_en = 1'b0,
   output logic tx_er = 1'b0,
   output logic [3:0] txd = 4'h0
);
   logic [3:0] last = 4'h0;
   always @(negedge clk) begin
      tx_en <= cmd.en;
      tx_er <= cmd.en & cmd.er;
      last <= cmd.en ? cmd.data : last;
      // Idle lines flip so stale data is never mistaken for a nibble
      if (!cmd.en)
         txd <= ~last;
      else if (rmii && !float_hi)
         txd <= {2'h0, cmd.data[1:0]};
      else
         txd <= cmd.data;
   end
endmodule

// *** verif/phy_mii_transmit_port_tb.sv ***
// Self-checking bench for the transmit port with a MAC model on its pins.
// Assumes a 20 MHz system clock and a free-running 400 ns reference clock.
`timescale 1ns/1ps
module phy_mii_transmit_port_tb;
   localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
      5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   logic clk = 1'b0, rst_n = 1'b0, ref_clk_in = 1'b0, irq_req = 1'b0;
   logic speed_100 = 1'b1, rmii_mode = 1'b0, symbol_mode = 1'b0, float_hi = 1'b1;
   logic [3:0] strap = 4'h0;
   pmt_pkg::pmt_tx_in_t cmd = '0;
   pmt_pkg::pmt_rx_t rx_in = '0;
   int seed = 99, n_mismatch = 0, samples_checked = 0, cyc = 0, cyc_all = 0;
   logic tx_en_in, shared_pin_in, interrupt_out_low, shared_pin_oe, tx_clk_out, er_drv;
   logic rxd_oe, rx_dv_out, rx_er_out, op_mode_strap_bit0, irq_pin_select_strap;
   logic [3:0] txd_in, rxd_out, rxd_pin_in;
   pmt_pkg::pmt_sym_t sym_out;
   wire mon = rmii_mode ? sym_out.valid : tx_clk_out;

   // Pin levels seen by the port: open-drain shared pin, strapped receive pins
   // The shared pin has a pull-up while the interrupt function is strapped
   assign shared_pin_in = shared_pin_oe ? interrupt_out_low : (strap[3] | er_drv);
   assign rxd_pin_in = rxd_oe ? rxd_out : strap;
   initial forever #25 clk = ~clk;
   initial forever #200 ref_clk_in = ~ref_clk_in;

   pmt_mac_model mac_u (.clk(clk), .rmii(rmii_mode), .float_hi(float_hi), .cmd(cmd),
      .tx_en(tx_en_in), .txd(txd_in), .tx_er(er_drv));
   pmt_tx_port dut_u (.clk(clk), .rst_n(rst_n), .ref_clk_in(ref_clk_in),
      .speed_100(speed_100), .rmii_mode(rmii_mode), .symbol_mode(symbol_mode),
      .tx_en_in(tx_en_in), .txd_in(txd_in), .shared_pin_in(shared_pin_in),
      .interrupt_out_low(interrupt_out_low), .shared_pin_oe(shared_pin_oe),
      .irq_req(irq_req), .tx_clk_out(tx_clk_out), .sym_out(sym_out), .rx_in(rx_in),
      .rxd_pin_in(rxd_pin_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rx_dv_out(rx_dv_out),
      .rx_er_out(rx_er_out), .op_mode_strap_bit0(op_mode_strap_bit0),
      .irq_pin_select_strap(irq_pin_select_strap));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic pmt_pkg::pmt_sym_t exp_sym(input pmt_pkg::pmt_tx_in_t c);
      logic er;
      er = c.er & ~strap[3];
      if (!c.en)
         return {1'b0, pmt_pkg::PMT_CODE_IDLE};
      if (rmii_mode)
         return {1'b1, ENC[{c.data[1:0], c.data[1:0]}]};
      if (!speed_100)
         return {2'b10, c.data};
      if (symbol_mode)
         return {1'b1, er, c.data};
      return {1'b1, er ? pmt_pkg::PMT_CODE_H : ENC[c.data]};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Waits for n rising edges of the watched output, cyc gives cycles taken
   task automatic ticks(input int n);
      logic p;
      p = mon;
      cyc = 0;
      while (n > 0 && cyc < 1000) begin
         @(negedge clk);
         if (mon && !p)
            n--;
         p = mon;
         cyc++;
      end
      if (n > 0)
         n_mismatch++;
   endtask

   task automatic do_reset(input logic [3:0] s);
      strap = s;
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      check(16'({sym_out, tx_clk_out, rxd_oe, rx_dv_out, rx_er_out, rxd_out}), 16'h1F00);
      rst_n = 1'b1;
      @(negedge clk);
      check(16'({op_mode_strap_bit0, irq_pin_select_strap, rxd_oe}), 16'({s[0], s[3], 1'b1}));
   endtask

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc_all <= cyc_all + 1;
      if (cyc_all == 60000) begin
         n_mismatch++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pmt_pkg::pmt_tx_in_t c;
      pmt_pkg::pmt_rx_t r;
      for (int s = 0; s < 2; s++) begin
         do_reset({s[0], 2'h0, 1'($random(seed))});
         irq_req <= 1'b1;
         @(negedge clk);
         check(16'({shared_pin_oe, interrupt_out_low}), 16'({s[0], 1'b0}));
         irq_req <= 1'b0;
         // Modes: 100 Mb/s coded, symbol bypass, 10 Mb/s, reduced-pin
         for (int md = 0; md < 4; md++) begin
            speed_100 <= (md != 2);
            symbol_mode <= (md == 1);
            rmii_mode <= (md == 3);
            cmd.en <= 1'b1;
            ticks(2);
            ticks(1);
            if (md != 3)
               check(16'(cyc), md == 2 ? 16'h0050 : 16'h0008);
            for (int i = 0; i < 12; i++) begin
               c = (i == 0) ? 6'h3F : 6'($random(seed));
               if (md == 3) begin
                  c.en = 1'b1;
                  float_hi <= i[0];
               end
               cmd <= c;
               ticks(3);
               check(16'(sym_out), 16'(exp_sym(c)));
               if (md == 3)
                  check(16'(tx_clk_out), 16'h0000);
            end
         end
      end
      repeat (20) begin
         r = 6'($random(seed));
         rx_in <= r;
         @(negedge clk);
         check(16'({rx_dv_out, rx_er_out, rxd_out}), 16'(r));
      end
      end_sim();
   end
endmodule
